// ===== include/pdo_pkg.sv
package pdo_pkg;

  localparam int unsigned NUM_OUT   = 4;
  localparam int unsigned VAL_W     = 16;
  localparam int unsigned SEL_W     = 5;
  localparam int unsigned NUM_VARS  = 32;

  // function codes shared by both combining stages
  localparam logic [3:0] FN_OR       = 4'h0;
  localparam logic [3:0] FN_SA_RB_R  = 4'h1;
  localparam logic [3:0] FN_RA_SB_R  = 4'h2;
  localparam logic [3:0] FN_SA_RB_F  = 4'h3;
  localparam logic [3:0] FN_RA_SB_F  = 4'h4;
  localparam logic [3:0] FN_AND      = 4'h5;
  localparam logic [3:0] FN_XOR      = 4'h6;
  localparam logic [3:0] FN_NOR      = 4'h7;
  localparam logic [3:0] FN_NAND     = 4'h8;

  // test kinds: bit 2 selects absolute value
  localparam logic [2:0] TK_GT  = 3'h0;
  localparam logic [2:0] TK_GE  = 3'h1;
  localparam logic [2:0] TK_LT  = 3'h2;
  localparam logic [2:0] TK_LE  = 3'h3;

  // access windows on the operating mode
  localparam logic [3:0] MODE_THR_MIN = 4'h2;
  localparam logic [3:0] MODE_FN_MAX  = 4'h9;

  // register map, one aligned word per output block of 8 words
  localparam logic [7:0] OUT_STRIDE   = 8'h20;
  localparam logic [4:0] R_MODE       = 5'h00;
  localparam logic [4:0] R_SEL        = 5'h04;
  localparam logic [4:0] R_KIND       = 5'h08;
  localparam logic [4:0] R_THR_A      = 5'h0c;
  localparam logic [4:0] R_THR_B      = 5'h10;
  localparam logic [4:0] R_FUNC       = 5'h14;
  localparam logic [4:0] R_POL        = 5'h18;
  localparam logic [4:0] R_STAT       = 5'h1c;
  localparam logic [7:0] REG_SPAN     = 8'h80;

  // reset values
  localparam logic [3:0]       RST_MODE = 4'h0;
  localparam logic [3:0]       RST_FUNC = 4'h0;
  localparam logic [VAL_W-1:0] RST_THR  = '0;
  localparam logic             RST_POL  = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : pdo_pkg

// ===== include/pdo_chain_if.sv
`timescale 1ns/10ps
// settings and results of one output chain
interface pdo_chain_if;
  import pdo_pkg::*;
  logic signed [VAL_W-1:0] var_a;
  logic signed [VAL_W-1:0] var_b;
  logic                    var_c;
  logic [2:0]              test_a_kind;
  logic [2:0]              test_b_kind;
  logic [VAL_W-1:0]        threshold_a;
  logic [VAL_W-1:0]        threshold_b;
  logic [3:0]              ab_combine_function;
  logic                    c_enable;
  logic [3:0]              second_stage_function;
  logic                    output_polarity;
  logic                    enable;
  logic                    result;
  logic                    ff_state;
  modport ctrl (output var_a, var_b, var_c, test_a_kind, test_b_kind, threshold_a,
                threshold_b, ab_combine_function, c_enable, second_stage_function,
                output_polarity, enable, input result, ff_state);
  modport chain (input var_a, var_b, var_c, test_a_kind, test_b_kind, threshold_a,
                 threshold_b, ab_combine_function, c_enable, second_stage_function,
                 output_polarity, enable, output result, ff_state);
endinterface : pdo_chain_if

// ===== rtl/pdo_chain.sv
`timescale 1ns/10ps
// one programmable output chain: two tests, two combining stages, polarity
module pdo_chain
  import pdo_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // settings and result
  pdo_chain_if.chain ch
);
  import pdo_pkg::*;

  // comparison of a value or its magnitude against a threshold
  function automatic logic run_test(input logic signed [VAL_W-1:0] v,
                                    input logic [VAL_W-1:0] thr, input logic [2:0] kind);
    logic signed [VAL_W:0] x;
    logic signed [VAL_W:0] t;
    x = kind[2] ? ((v < 0) ? -{v[VAL_W-1], v} : {v[VAL_W-1], v}) : {v[VAL_W-1], v};
    t = {thr[VAL_W-1], thr};
    case (kind[1:0])
      2'h0:    run_test = x > t;
      2'h1:    run_test = x >= t;
      2'h2:    run_test = x < t;
      default: run_test = x <= t;
    endcase
  endfunction : run_test

  // static Boolean function of two inputs
  function automatic logic comb_fn(input logic a, input logic b, input logic [3:0] f);
    case (f)
      FN_OR:   comb_fn = a | b;
      FN_AND:  comb_fn = a & b;
      FN_XOR:  comb_fn = a ^ b;
      FN_NOR:  comb_fn = ~a & ~b;
      FN_NAND: comb_fn = ~a | ~b;
      default: comb_fn = 1'b0;
    endcase
  endfunction : comb_fn

  // edge-driven set/reset: a edge has priority over b edge
  function automatic logic ff_next(input logic q, input logic a, input logic b,
                                   input logic pa, input logic pb, input logic [3:0] f);
    logic ra;
    logic rb;
    logic fa;
    logic fb;
    ra = a & ~pa;
    rb = b & ~pb;
    fa = ~a & pa;
    fb = ~b & pb;
    ff_next = q;
    case (f)
      FN_SA_RB_R: ff_next = ra ? 1'b1 : (rb ? 1'b0 : q);
      FN_RA_SB_R: ff_next = ra ? 1'b0 : (rb ? 1'b1 : q);
      FN_SA_RB_F: ff_next = fa ? 1'b1 : (fb ? 1'b0 : q);
      FN_RA_SB_F: ff_next = fa ? 1'b0 : (fb ? 1'b1 : q);
      default:    ff_next = q;
    endcase
  endfunction : ff_next

  function automatic logic is_ff(input logic [3:0] f);
    is_ff = (f >= FN_SA_RB_R) && (f <= FN_RA_SB_F);
  endfunction : is_ff

  logic test_a;
  logic test_b;
  logic ab_ff_q;
  logic ab_ff_d;
  logic prev_a_q;
  logic prev_b_q;
  logic c_ff_q;
  logic c_ff_d;
  logic prev_ab_q;
  logic prev_c_q;
  logic ab_res;
  logic c_res;
  logic chain_res;
  logic out_q;

  // tests against thresholds
  assign test_a = run_test(ch.var_a, ch.threshold_a, ch.test_a_kind);
  assign test_b = run_test(ch.var_b, ch.threshold_b, ch.test_b_kind);

  // first stage
  assign ab_ff_d = ff_next(ab_ff_q, test_a, test_b, prev_a_q, prev_b_q,
                           ch.ab_combine_function);
  assign ab_res  = is_ff(ch.ab_combine_function) ? ab_ff_q
                   : comb_fn(test_a, test_b, ch.ab_combine_function);

  // second stage, same function set
  assign c_ff_d    = ff_next(c_ff_q, ab_res, ch.var_c, prev_ab_q, prev_c_q,
                             ch.second_stage_function);
  assign c_res     = is_ff(ch.second_stage_function) ? c_ff_q
                     : comb_fn(ab_res, ch.var_c, ch.second_stage_function);
  assign chain_res = ch.c_enable ? c_res : ab_res;

  // edge history and flip-flop state
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ab_ff_q   <= 1'b0;
      prev_a_q  <= 1'b0;
      prev_b_q  <= 1'b0;
      c_ff_q    <= 1'b0;
      prev_ab_q <= 1'b0;
      prev_c_q  <= 1'b0;
      out_q     <= 1'b0;
    end
    else
    begin
      ab_ff_q   <= ab_ff_d;
      prev_a_q  <= test_a;
      prev_b_q  <= test_b;
      c_ff_q    <= c_ff_d;
      prev_ab_q <= ab_res;
      prev_c_q  <= ch.var_c;
      out_q     <= ch.enable & (ch.output_polarity ? chain_res : ~chain_res);
    end
  end

  assign ch.result   = out_q;
  assign ch.ff_state = ab_ff_q;

endmodule : pdo_chain

// ===== rtl/pdo_top.sv
`timescale 1ns/10ps
// four programmable digital outputs with an axi4-lite register port
module pdo_top
  import pdo_pkg::*;
(
  // clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_n_i,
  // internal drive variables, same clock
  input  wire logic [pdo_pkg::NUM_VARS*pdo_pkg::VAL_W-1:0] analog_vars_i,
  input  wire logic [pdo_pkg::NUM_VARS-1:0]         digital_vars_i,
  // axi4-lite write address and data
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [7:0]                           s_axi_awaddr,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  // axi4-lite write response
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  output logic [1:0]                                s_axi_bresp,
  // axi4-lite read
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  input  wire logic [7:0]                           s_axi_araddr,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  // programmable digital outputs
  output logic [pdo_pkg::NUM_OUT-1:0]               prog_digital_output_o
);
  import pdo_pkg::*;

  // per-output settings
  logic [3:0]       mode_q   [NUM_OUT];
  logic [SEL_W-1:0] sel_a_q  [NUM_OUT];
  logic [SEL_W-1:0] sel_b_q  [NUM_OUT];
  logic [SEL_W-1:0] sel_c_q  [NUM_OUT];
  logic [2:0]       kind_a_q [NUM_OUT];
  logic [2:0]       kind_b_q [NUM_OUT];
  logic [VAL_W-1:0] thr_a_q  [NUM_OUT];
  logic [VAL_W-1:0] thr_b_q  [NUM_OUT];
  logic [3:0]       fn_ab_q  [NUM_OUT];
  logic [3:0]       fn_c_q   [NUM_OUT];
  logic             pol_q    [NUM_OUT];
  logic [NUM_OUT-1:0] res;
  logic [NUM_OUT-1:0] ffs;

  // write and read channel holding registers
  logic             aw_full_q;
  logic [7:0]       aw_addr_q;
  logic             w_full_q;
  logic [31:0]      w_data_q;
  logic [3:0]       w_strb_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             arready_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;

  // write decode
  wire       do_wr    = aw_full_q & w_full_q & ~bvalid_q;
  wire [1:0] wr_idx   = aw_addr_q[6:5];
  wire [4:0] wr_off   = aw_addr_q[4:0];
  wire       wr_ok    = (aw_addr_q < REG_SPAN) && (aw_addr_q[1:0] == 2'b00);
  wire [3:0] wr_mode  = mode_q[wr_idx];
  wire       thr_open = wr_mode > MODE_THR_MIN;
  wire       fn_open  = (wr_mode > MODE_THR_MIN) && (wr_mode < MODE_FN_MAX);
  wire       pol_open = wr_mode != 4'h0;

  // read decode
  wire       do_rd    = s_axi_arvalid & arready_q;
  wire [1:0] rd_idx   = s_axi_araddr[6:5];
  wire [4:0] rd_off   = s_axi_araddr[4:0];
  wire       rd_ok    = (s_axi_araddr < REG_SPAN) && (s_axi_araddr[1:0] == 2'b00);
  logic [31:0] rd_word;

  // read data mux
  always_comb
  begin
    rd_word = 32'h0;
    case (rd_off)
      R_MODE:  rd_word = {28'h0, mode_q[rd_idx]};
      R_SEL:   rd_word = {11'h0, sel_c_q[rd_idx], 3'h0, sel_b_q[rd_idx], 3'h0,
                          sel_a_q[rd_idx]};
      R_KIND:  rd_word = {25'h0, kind_b_q[rd_idx], 1'b0, kind_a_q[rd_idx]};
      R_THR_A: rd_word = {16'h0, thr_a_q[rd_idx]};
      R_THR_B: rd_word = {16'h0, thr_b_q[rd_idx]};
      R_FUNC:  rd_word = {24'h0, fn_c_q[rd_idx], fn_ab_q[rd_idx]};
      R_POL:   rd_word = {31'h0, pol_q[rd_idx]};
      R_STAT:  rd_word = {30'h0, ffs[rd_idx], res[rd_idx]};
      default: rd_word = 32'h0;
    endcase
  end

  // address and data capture, response
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h0;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // settings registers, locked fields ignore writes
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        mode_q[i]   <= RST_MODE;
        sel_a_q[i]  <= '0;
        sel_b_q[i]  <= '0;
        sel_c_q[i]  <= '0;
        kind_a_q[i] <= TK_GT;
        kind_b_q[i] <= TK_GT;
        thr_a_q[i]  <= RST_THR;
        thr_b_q[i]  <= RST_THR;
        fn_ab_q[i]  <= RST_FUNC;
        fn_c_q[i]   <= RST_FUNC;
        pol_q[i]    <= RST_POL;
      end
    end
    else if (do_wr && wr_ok && w_strb_q[0])
    begin
      case (wr_off)
        R_MODE:  mode_q[wr_idx] <= w_data_q[3:0];
        R_SEL:
        begin
          sel_a_q[wr_idx] <= w_data_q[4:0];
          sel_b_q[wr_idx] <= w_strb_q[1] ? w_data_q[12:8] : sel_b_q[wr_idx];
          sel_c_q[wr_idx] <= w_strb_q[2] ? w_data_q[20:16] : sel_c_q[wr_idx];
        end
        R_KIND:
        begin
          kind_a_q[wr_idx] <= w_data_q[2:0];
          kind_b_q[wr_idx] <= w_data_q[6:4];
        end
        R_THR_A: if (thr_open && w_strb_q[1]) thr_a_q[wr_idx] <= w_data_q[15:0];
        R_THR_B: if (thr_open && w_strb_q[1]) thr_b_q[wr_idx] <= w_data_q[15:0];
        R_FUNC:
        begin
          if (fn_open) fn_ab_q[wr_idx] <= w_data_q[3:0];
          fn_c_q[wr_idx] <= w_data_q[7:4];
        end
        R_POL:   if (pol_open) pol_q[wr_idx] <= w_data_q[0];
        default: ;
      endcase
    end
  end

  // read channel
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      arready_q <= ~rvalid_q & ~do_rd;
      if (do_rd)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_ok ? rd_word : 32'h0;
        rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // four independent chains
  generate
    for (genvar g = 0; g < NUM_OUT; g++)
    begin : g_out
      pdo_chain_if cif ();
      assign cif.var_a       = analog_vars_i[sel_a_q[g]*VAL_W +: VAL_W];
      assign cif.var_b       = analog_vars_i[sel_b_q[g]*VAL_W +: VAL_W];
      assign cif.var_c       = digital_vars_i[sel_c_q[g]];
      assign cif.c_enable    = sel_c_q[g] != '0;
      assign cif.test_a_kind = kind_a_q[g];
      assign cif.test_b_kind = kind_b_q[g];
      assign cif.threshold_a = thr_a_q[g];
      assign cif.threshold_b = thr_b_q[g];
      assign cif.ab_combine_function   = fn_ab_q[g];
      assign cif.second_stage_function = fn_c_q[g];
      assign cif.output_polarity       = pol_q[g];
      assign cif.enable      = mode_q[g] != 4'h0;
      assign res[g]          = cif.result;
      assign ffs[g]          = cif.ff_state;
      pdo_chain u_chain (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ch      (cif)
      );
    end
  endgenerate

  assign s_axi_awready         = ~aw_full_q;
  assign s_axi_wready          = ~w_full_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = arready_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rdata           = rdata_q;
  assign s_axi_rresp           = rresp_q;
  assign prog_digital_output_o = res;

endmodule : pdo_top

// ===== verif/pdo_checker.sv
`timescale 1ns/10ps
// bus handshake and output checks seen from the top ports
module pdo_checker
  import pdo_pkg::*;
(
  // clock and reset
  input wire logic               clk_i, rst_n_i,
  // write channels
  input wire logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic [7:0]         s_axi_awaddr,
  input wire logic [31:0]        s_axi_wdata,
  input wire logic [3:0]         s_axi_wstrb,
  input wire logic               s_axi_bvalid, s_axi_bready,
  input wire logic [1:0]         s_axi_bresp,
  // read channels
  input wire logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [7:0]         s_axi_araddr,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  // outputs
  input wire logic [NUM_OUT-1:0] prog_digital_output_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] mz_q, mz1_q, mz2_q;
  logic       wr_go;
  // both write halves taken in one edge
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // shadow of which outputs have mode zero, with two delayed copies
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mz_q  <= 4'hf;
      mz1_q <= 4'hf;
      mz2_q <= 4'hf;
    end
    else
    begin
      if (wr_go && !s_axi_awaddr[7] && s_axi_awaddr[4:0] == 5'h00 && s_axi_wstrb[0])
        mz_q[s_axi_awaddr[6:5]] <= (s_axi_wdata[3:0] == 4'h0);
      mz1_q <= mz_q;
      mz2_q <= mz1_q;
    end
  end
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_time; wr_go |-> ##[1:2] s_axi_bvalid; endproperty
  property p_w_err; wr_go && s_axi_awaddr[7] |-> ##[1:2] s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  property p_r_err; s_axi_arvalid && s_axi_arready && s_axi_araddr >= REG_SPAN
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
  property p_r_ok; s_axi_arvalid && s_axi_arready && s_axi_araddr < REG_SPAN
    && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY; endproperty
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_mode_off;
    (prog_digital_output_o & mz_q & mz1_q & mz2_q & $past(mz2_q)) == 4'h0;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  a_b_time: assert property (p_b_time) else $error("write response late");
  a_w_err: assert property (p_w_err) else $error("unmapped write not refused");
  a_r_err: assert property (p_r_err) else $error("unmapped read not refused");
  a_r_ok: assert property (p_r_ok) else $error("mapped read refused");
  a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
  a_mode_off: assert property (p_mode_off) else $error("output high in mode zero");
  // main scenarios
  c_wr_err: cover property (wr_go && s_axi_awaddr[7]);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_out: cover property ($rose(prog_digital_output_o[0]));
endmodule : pdo_checker

bind pdo_top pdo_checker pdo_checker_inst (.clk_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_araddr, .s_axi_rdata, .s_axi_rresp, .prog_digital_output_o);

// ===== verif/pdo_top_tb.sv
`timescale 1ns/10ps
// bench for the four programmable outputs
module pdo_top_tb;
  import pdo_pkg::*;
  logic                      clk_i, rst_n_i;
  logic [NUM_VARS*VAL_W-1:0] analog_vars_i;
  logic [NUM_VARS-1:0]       digital_vars_i;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]                s_axi_awaddr, s_axi_araddr;
  logic [31:0]               s_axi_wdata, s_axi_rdata;
  logic [3:0]                s_axi_wstrb;
  logic [1:0]                s_axi_bresp, s_axi_rresp;
  logic [NUM_OUT-1:0]        prog_digital_output_o;
  int                        n_errors, n_compared, cycles;
  logic [3:0]                fl [5] = '{FN_OR, FN_AND, FN_XOR, FN_NOR, FN_NAND};
  localparam logic [15:0]    TV = 16'h0005;
  localparam logic [15:0]    FV = 16'hfffb;

  pdo_top pdo_top_inst (.clk_i, .rst_n_i, .analog_vars_i, .digital_vars_i, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .prog_digital_output_o);

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task give_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done)
    begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        done = 1'b1;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done)
    begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        done = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, d & 32'hffff, e);
  endtask : rchk

  // drive variable a, b and the boolean c, then let the chain settle
  task automatic ab(input logic [15:0] a, input logic [15:0] b, input logic c, input int w);
    analog_vars_i[VAL_W +: VAL_W]   <= a;
    analog_vars_i[2*VAL_W +: VAL_W] <= b;
    digital_vars_i[3]               <= c;
    repeat (w) @(posedge clk_i);
  endtask : ab

  function automatic logic comb(input logic [3:0] f, input logic a, input logic b);
    case (f)
      FN_OR:   return a | b;
      FN_AND:  return a & b;
      FN_XOR:  return a ^ b;
      FN_NOR:  return ~(a | b);
      default: return ~(a & b);
    endcase
  endfunction : comb

  function automatic logic tst(input logic signed [15:0] v, input logic signed [15:0] t,
                               input logic [2:0] k);
    logic signed [15:0] x;
    x = (k[2] && v < 0) ? -v : v;
    case (k[1:0])
      2'h0:    return x > t;
      2'h1:    return x >= t;
      2'h2:    return x < t;
      default: return x <= t;
    endcase
  endfunction : tst

  // main sequence
  initial
  begin
    int          n;
    logic        q, pa, pb, ea, eb, kn, a, b;
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] vl [6] = '{16'h0003, 16'hfffd, 16'h0004, 16'hfffc, 16'h0002, 16'h0000};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb    = 4'hf;
    analog_vars_i  = '0;
    digital_vars_i = '0;
    rst_n_i        = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rchk("mode", R_MODE, {28'h0, RST_MODE});
    rchk("stat", R_STAT, 32'h0);
    // locked fields in modes 0, 9 and 2
    wr(R_THR_A, 32'h5, RESP_OKAY);
    wr(R_FUNC, 32'h5, RESP_OKAY);
    wr(R_POL, 32'h0, RESP_OKAY);
    rchk("thra", R_THR_A, 32'h0);
    rchk("func", R_FUNC, 32'h0);
    rchk("pol", R_POL, {31'h0, RST_POL});
    wr(R_MODE, 32'h9, RESP_OKAY);
    wr(R_THR_B, 32'h7, RESP_OKAY);
    wr(R_FUNC, 32'h5, RESP_OKAY);
    wr(R_POL, 32'h0, RESP_OKAY);
    rchk("thrb", R_THR_B, 32'h7);
    rchk("func", R_FUNC, 32'h0);
    rchk("pol", R_POL, 32'h0);
    wr(R_MODE, 32'h2, RESP_OKAY);
    wr(R_THR_B, 32'h3, RESP_OKAY);
    wr(R_FUNC, 32'h5, RESP_OKAY);
    rchk("thrb", R_THR_B, 32'h7);
    rchk("func", R_FUNC, 32'h0);
    // refused accesses
    wr(8'h80, 32'h0, RESP_SLVERR);
    wr(8'h02, 32'h0, RESP_SLVERR);
    rd(8'h80, d, r);
    chk("rresp", {d[29:0], r}, {30'h0, RESP_SLVERR});
    // all four chains in mode 3, a on variable 1, b on variable 2
    for (n = 0; n < 4; n++)
    begin
      wr(8'(n * 32), 32'h3, RESP_OKAY);
      wr(8'(n * 32 + R_SEL), 32'h0201, RESP_OKAY);
    end
    wr(R_THR_B, 32'h0, RESP_OKAY);
    wr(R_POL, 32'h1, RESP_OKAY);
    // static functions, each chain rotated through the list
    for (int i = 0; i < 5; i++)
    begin
      for (n = 0; n < 4; n++)
        wr(8'(n * 32 + R_FUNC), {28'h0, fl[(i + n) % 5]}, RESP_OKAY);
      for (int k = 0; k < 4; k++)
      begin
        ab(k[0] ? TV : FV, k[1] ? TV : FV, 1'b0, 3);
        for (n = 0; n < 4; n++)
          chk("out", {31'h0, prog_digital_output_o[n]},
              {31'h0, comb(fl[(i + n) % 5], k[0], k[1])});
      end
    end
    // second stage against c
    wr(R_SEL, 32'h30201, RESP_OKAY);
    for (int j = 0; j < 5; j++)
    begin
      wr(R_FUNC, {24'h0, fl[j], FN_OR}, RESP_OKAY);
      for (int k = 0; k < 4; k++)
      begin
        ab(k[0] ? TV : FV, FV, k[1], 3);
        chk("stage2", {31'h0, prog_digital_output_o[0]}, {31'h0, comb(fl[j], k[0], k[1])});
      end
    end
    // c disabled, then both polarities
    wr(R_SEL, 32'h0201, RESP_OKAY);
    for (int p = 1; p >= 0; p--)
    begin
      wr(R_POL, 32'(p), RESP_OKAY);
      for (int k = 0; k < 2; k++)
      begin
        ab(k[0] ? TV : FV, FV, 1'b1, 3);
        chk("pol", {31'h0, prog_digital_output_o[0]}, {31'h0, k[0] ~^ p[0]});
      end
    end
    wr(R_POL, 32'h1, RESP_OKAY);
    // every test kind against both thresholds
    wr(R_FUNC, {28'h0, FN_OR}, RESP_OKAY);
    wr(R_THR_A, 32'h3, RESP_OKAY);
    wr(R_THR_B, 32'hfffd, RESP_OKAY);
    for (int k = 0; k < 8; k++)
    begin
      wr(R_KIND, 32'(k * 17), RESP_OKAY);
      for (int v = 0; v < 6; v++)
      begin
        ab(vl[v], vl[v], 1'b0, 3);
        chk("kind", {31'h0, prog_digital_output_o[0]},
            {31'h0, tst(vl[v], 16'h0003, 3'(k)) | tst(vl[v], 16'hfffd, 3'(k))});
      end
    end
    wr(R_KIND, 32'h0, RESP_OKAY);
    wr(R_THR_A, 32'h0, RESP_OKAY);
    wr(R_THR_B, 32'h0, RESP_OKAY);
    // flip-flop modes over one edge sequence, coincident edges included
    for (int f = 1; f < 5; f++)
    begin
      wr(R_FUNC, 32'(f), RESP_OKAY);
      ab(FV, FV, 1'b0, 4);
      {q, pa, pb, kn} = 4'h0;
      for (int s = 0; s < 10; s++)
      begin
        a = 10'b1001010011 >> s;
        b = 10'b0011011000 >> s;
        ab(a ? TV : FV, b ? TV : FV, 1'b0, 4);
        ea = (f < 3) ? (a && !pa) : (!a && pa);
        eb = (f < 3) ? (b && !pb) : (!b && pb);
        if (ea)
          q = (f == 1 || f == 3);
        else if (eb)
          q = !(f == 1 || f == 3);
        kn = kn | ea | eb;
        pa = a;
        pb = b;
        if (kn)
        begin
          chk("ff", {31'h0, prog_digital_output_o[0]}, {31'h0, q});
          rchk("ffstat", R_STAT, {30'h0, q, q});
        end
      end
    end
    // second stage as a flip-flop: a rise of f(A,B) sets, a rise of c clears
    wr(R_SEL, 32'h30201, RESP_OKAY);
    wr(R_FUNC, {24'h0, FN_SA_RB_R, FN_OR}, RESP_OKAY);
    for (int s = 0; s < 6; s++)
    begin
      a = 6'b100010 >> s;
      b = 6'b010111 >> s;
      q = 6'b101110 >> s;
      ab(a ? TV : FV, FV, b, 4);
      chk("ff2", {31'h0, prog_digital_output_o[0]}, {31'h0, q});
    end
    give_verdict();
  end
endmodule : pdo_top_tb
